// >>> src/booster_pump_controller.sv
// Booster pump controller: pressure control, rotation, kick, top-up valve, relays.
// Assumes contacts already debounced and synchronous; pressure is a scaled 4-20 mA value.
//
// Operation
// - Open top-up enable blocks new top-up and aborts a running one.
// - Top-up enable overrides float level and manual valve commands.
// - Collective run relay shows whether any pump runs.
// - Collective fault relay shows any fault of the pump set.
// - Burner fault relay on dry run, under, overpressure or sensor error.
// - Each pump has a run relay closed while it runs.
// - Combined pump fault relay when either or both pumps faulted.
// - Two-position control keeps pressure between the two thresholds.
// - Thresholds are setpoint plus a signed offset.
// - Duty pump starts below activation if remote on, no fault, drives on.
// - Never more than one pump running.
// - Above deactivation the pump stops after the full delay.
// - Valve opens on low level with enable, remote on and drives on.
// - Valve open too long raises alarm, stops pumps, keeps valve shut.
// - Short top-up intervals raise alarm after a band-dependent delay.
// - Duty role passes to the other pump at each fresh start.
// - Optional cycling swaps the duty pump every six hours.
// - Kick run after idle interval; may be allowed under remote off.
// - Standby pump runs only on duty fault, or during kick.
// - Standstill time of each pump is counted; only the standby pump's time is readable.
// - Remote off stops pumps and valve over demand and manual mode.
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
module booster_pump_controller #(
	parameter int TICK_CYCLES = bpc_pkg::TICK_CYC
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Contacts and sensor
	input  wire logic        remote_on,
	input  wire logic        topup_en,
	input  wire logic        float_ok,
	input  wire logic        dry_ok,
	input  wire logic [1:0]  pump_fault_contact,
	input  wire logic        sensor_err,
	input  wire logic [15:0] pressure,
	// Actuators and relays
	output logic      [1:0]  pump_run,
	output logic             valve_open,
	output logic             collective_run_output,
	output logic             collective_fault_output,
	output logic             burner_fault_output,
	output logic      [1:0]  per_pump_run_output,
	output logic             combined_pump_fault_output
);
	function automatic logic signed [17:0] lvl(input logic [15:0] sp, input logic [15:0] off);
		lvl = $signed({2'b00, sp}) + $signed({{2{off[15]}}, off});
	endfunction : lvl
	function automatic logic [31:0] band_dly(input logic [31:0] gap);
		band_dly = (gap <= bpc_pkg::GAP3) ? bpc_pkg::DLY3 :
		           (gap <= bpc_pkg::GAP4) ? bpc_pkg::DLY4 :
		           (gap <= bpc_pkg::GAP5) ? bpc_pkg::DLY5 : bpc_pkg::DLY6;
	endfunction : band_dly

	// Bus and configuration registers
	logic [6:0]  ctrl_q, ctrl_d;
	logic [15:0] setpt_q, setpt_d, dly_q, dly_d, vmax_q, vmax_d;
	logic [31:0] thr_q, thr_d, kick_q, kick_d, lim_q, lim_d, rdat_d;
	logic        ack_d, clr_d, clr_q;
	logic        wr;
	// Timers
	logic [31:0] tick_cnt_q, tick_cnt_d;
	logic        tick_q, tick_d;
	// Pump control
	bpc_pkg::pump_st_t st_q, st_d;
	logic        duty_q, duty_d;
	logic [31:0] dly_s_q, dly_s_d, idle_s_q, idle_s_d, kick_s_q, kick_s_d, cyc_s_q, cyc_s_d;
	logic [31:0] still_q [2];
	logic [31:0] still_d [2];
	logic [1:0]  run_d;
	// Top-up
	logic        valve_d, v_alarm_q, v_alarm_d, f_alarm_q, f_alarm_d, seq_q, seq_d;
	logic [31:0] open_s_q, open_s_d, gap_s_q, gap_s_d, seq_s_q, seq_s_d, flim_q, flim_d;
	// Shared decode
	logic        below, above, under, over, burner, sys_fault, allow, kick_ok, sb;
	logic [1:0]  vm;

	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign vm = ctrl_q[bpc_pkg::B_VM +: 2];
	assign under = pressure < lim_q[15:0];
	assign over = pressure > lim_q[31:16];
	assign burner = !dry_ok || under || over || sensor_err;
	assign sys_fault = !dry_ok || sensor_err || v_alarm_q || f_alarm_q;
	assign allow = remote_on && ctrl_q[bpc_pkg::B_DRV] && !sys_fault;
	assign kick_ok = ctrl_q[bpc_pkg::B_KICK] && ctrl_q[bpc_pkg::B_DRV] && !sys_fault
		&& (remote_on || ctrl_q[bpc_pkg::B_KOFF]);
	assign below = $signed({2'b00, pressure}) < lvl(setpt_q, thr_q[15:0]);
	assign above = $signed({2'b00, pressure}) > lvl(setpt_q, thr_q[31:16]);
	assign sb = !duty_q;

	always_comb begin
		ctrl_d = ctrl_q;
		setpt_d = setpt_q;
		thr_d = thr_q;
		dly_d = dly_q;
		vmax_d = vmax_q;
		kick_d = kick_q;
		lim_d = lim_q;
		clr_d = 1'b0;
		ack_d = wb_cyc_i && wb_stb_i && !wb_ack_o;
		rdat_d = 32'h0000_0000;
		if (wr && wb_sel_i[0]) begin
			case (wb_adr_i)
				bpc_pkg::A_CTRL: begin
					ctrl_d = {1'b0, wb_dat_i[5:0]};
					clr_d = wb_dat_i[bpc_pkg::B_CLR];
				end
				bpc_pkg::A_SETPT: setpt_d = wb_dat_i[15:0];
				bpc_pkg::A_THR: thr_d = wb_dat_i;
				bpc_pkg::A_DLY: dly_d = wb_dat_i[15:0];
				bpc_pkg::A_VMAX: vmax_d = wb_dat_i[15:0];
				bpc_pkg::A_KICK: kick_d = wb_dat_i;
				bpc_pkg::A_LIM: lim_d = wb_dat_i;
				default: ;
			endcase
		end
		case (wb_adr_i)
			bpc_pkg::A_CTRL: rdat_d = {26'h0, ctrl_q[5:0]};
			bpc_pkg::A_SETPT: rdat_d = {16'h0, setpt_q};
			bpc_pkg::A_THR: rdat_d = thr_q;
			bpc_pkg::A_DLY: rdat_d = {16'h0, dly_q};
			bpc_pkg::A_VMAX: rdat_d = {16'h0, vmax_q};
			bpc_pkg::A_KICK: rdat_d = kick_q;
			bpc_pkg::A_LIM: rdat_d = lim_q;
			bpc_pkg::A_STAT: rdat_d = {23'h0, st_q, burner, f_alarm_q, v_alarm_q,
				duty_q, valve_open, pump_run};
			bpc_pkg::A_IDLE: rdat_d = still_q[sb];
			default: rdat_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q <= bpc_pkg::CTRL_RST;
			setpt_q <= 16'h0000;
			thr_q <= 32'h0000_0000;
			dly_q <= 16'h0000;
			vmax_q <= 16'h0000;
			kick_q <= 32'h0000_0000;
			lim_q <= 32'hFFFF_0000;
			clr_q <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			ctrl_q <= ctrl_d;
			setpt_q <= setpt_d;
			thr_q <= thr_d;
			dly_q <= dly_d;
			vmax_q <= vmax_d;
			kick_q <= kick_d;
			lim_q <= lim_d;
			clr_q <= clr_d;
			wb_ack_o <= ack_d;
			wb_dat_o <= rdat_d;
		end
	end

	// One-second tick shared by all timers
	always_comb begin
		tick_d = tick_cnt_q == 32'(TICK_CYCLES - 1);
		tick_cnt_d = tick_d ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt_q <= 32'h0000_0000;
			tick_q <= 1'b0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			tick_q <= tick_d;
		end
	end

	// Pump sequencing; one pump chosen at a time by construction
	always_comb begin
		st_d = st_q;
		duty_d = duty_q;
		dly_s_d = (st_q == bpc_pkg::P_STOP && tick_q) ? dly_s_q + 32'h1 : dly_s_q;
		idle_s_d = (st_q == bpc_pkg::P_IDLE && tick_q) ? idle_s_q + 32'h1 : idle_s_q;
		kick_s_d = (st_q == bpc_pkg::P_KICK && tick_q) ? kick_s_q + 32'h1 : kick_s_q;
		cyc_s_d = (ctrl_q[bpc_pkg::B_CYC] && tick_q) ? cyc_s_q + 32'h1 : cyc_s_q;
		if (!ctrl_q[bpc_pkg::B_CYC]) begin
			cyc_s_d = 32'h0;
		end else if (cyc_s_q >= bpc_pkg::CYCLE_S) begin
			cyc_s_d = 32'h0;
			duty_d = !duty_q;
		end
		case (st_q)
			bpc_pkg::P_IDLE: begin
				if (allow && below) begin
					st_d = bpc_pkg::P_RUN;
					duty_d = !duty_q;
				end else if (kick_ok && kick_q[15:0] != 16'h0
					&& idle_s_q >= 32'(kick_q[15:0]) * bpc_pkg::S_PER_MIN) begin
					st_d = bpc_pkg::P_KICK;
					kick_s_d = 32'h0;
				end
			end
			bpc_pkg::P_RUN: begin
				if (!allow) st_d = bpc_pkg::P_IDLE;
				else if (above) begin
					st_d = bpc_pkg::P_STOP;
					dly_s_d = 32'h0;
				end
			end
			bpc_pkg::P_STOP: begin
				if (!allow) st_d = bpc_pkg::P_IDLE;
				else if (!above) st_d = bpc_pkg::P_RUN;
				else if (dly_s_q > 32'(dly_q)) st_d = bpc_pkg::P_IDLE;
			end
			bpc_pkg::P_KICK: begin
				if (allow && below) st_d = bpc_pkg::P_RUN;
				else if (!kick_ok || kick_s_q >= 32'(kick_q[31:16])) st_d = bpc_pkg::P_IDLE;
			end
			default: st_d = bpc_pkg::P_IDLE;
		endcase
		if (st_d != bpc_pkg::P_IDLE) idle_s_d = 32'h0;
		run_d = 2'b00;
		if (st_d == bpc_pkg::P_RUN || st_d == bpc_pkg::P_STOP) begin
			// Standby steps in only for a faulted duty pump
			if (!pump_fault_contact[duty_d]) run_d[duty_d] = 1'b1;
			else if (!pump_fault_contact[!duty_d]) run_d[!duty_d] = 1'b1;
		end else if (st_d == bpc_pkg::P_KICK) begin
			// Kick exercises the standby pump, which otherwise sits still
			if (!pump_fault_contact[!duty_d]) run_d[!duty_d] = 1'b1;
			else if (!pump_fault_contact[duty_d]) run_d[duty_d] = 1'b1;
		end
		for (int i = 0; i < 2; i++) begin
			still_d[i] = still_q[i];
			if (pump_run[i]) still_d[i] = 32'h0;
			else if (tick_q && still_q[i] != 32'hFFFF_FFFF) still_d[i] = still_q[i] + 32'h1;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= bpc_pkg::P_IDLE;
			duty_q <= 1'b0;
			dly_s_q <= 32'h0;
			idle_s_q <= 32'h0;
			kick_s_q <= 32'h0;
			cyc_s_q <= 32'h0;
			still_q[0] <= 32'h0;
			still_q[1] <= 32'h0;
			pump_run <= 2'b00;
		end else begin
			st_q <= st_d;
			duty_q <= duty_d;
			dly_s_q <= dly_s_d;
			idle_s_q <= idle_s_d;
			kick_s_q <= kick_s_d;
			cyc_s_q <= cyc_s_d;
			still_q[0] <= still_d[0];
			still_q[1] <= still_d[1];
			pump_run <= run_d;
		end
	end

	// Top-up valve and its supervision
	always_comb begin
		valve_d = topup_en && remote_on && ctrl_q[bpc_pkg::B_DRV] && !v_alarm_q && !f_alarm_q
			&& (vm == bpc_pkg::VM_OPEN || (vm == bpc_pkg::VM_AUTO && !float_ok));
		open_s_d = !valve_open ? 32'h0 : (tick_q ? open_s_q + 32'h1 : open_s_q);
		gap_s_d = (!valve_open && tick_q && gap_s_q <= bpc_pkg::GAP6) ? gap_s_q + 32'h1 : gap_s_q;
		seq_d = seq_q;
		flim_d = flim_q;
		seq_s_d = (seq_q && tick_q) ? seq_s_q + 32'h1 : seq_s_q;
		if (valve_d && !valve_open) begin
			gap_s_d = 32'h0;
			seq_d = gap_s_q <= bpc_pkg::GAP6;
			flim_d = band_dly(gap_s_q);
			if (!seq_q) seq_s_d = 32'h0;
		end else if (gap_s_q > bpc_pkg::GAP6) begin
			seq_d = 1'b0;
			seq_s_d = 32'h0;
		end
		// Alarm set wins over a clear in the same cycle
		v_alarm_d = (valve_open && vmax_q != 16'h0 && open_s_q > 32'(vmax_q))
			|| (v_alarm_q && !clr_q);
		f_alarm_d = (seq_q && seq_s_q >= flim_q) || (f_alarm_q && !clr_q);
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			valve_open <= 1'b0;
			open_s_q <= 32'h0;
			gap_s_q <= bpc_pkg::GAP6 + 32'h1;
			seq_q <= 1'b0;
			seq_s_q <= 32'h0;
			flim_q <= bpc_pkg::DLY6;
			v_alarm_q <= 1'b0;
			f_alarm_q <= 1'b0;
		end else begin
			valve_open <= valve_d;
			open_s_q <= open_s_d;
			gap_s_q <= gap_s_d;
			seq_q <= seq_d;
			seq_s_q <= seq_s_d;
			flim_q <= flim_d;
			v_alarm_q <= v_alarm_d;
			f_alarm_q <= f_alarm_d;
		end
	end

	// Relay outputs
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			collective_run_output <= 1'b0;
			collective_fault_output <= 1'b0;
			burner_fault_output <= 1'b0;
			per_pump_run_output <= 2'b00;
			combined_pump_fault_output <= 1'b0;
		end else begin
			collective_run_output <= |run_d;
			collective_fault_output <= sys_fault || burner || |pump_fault_contact;
			burner_fault_output <= burner;
			per_pump_run_output <= run_d;
			combined_pump_fault_output <= |pump_fault_contact;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	one_pump_a: assert property (!(pump_run[0] && pump_run[1]))
		else $error("two pumps running");
	enable_off_a: assert property (!topup_en |=> !valve_open)
		else $error("valve open with enable off");
	manual_blocked_a: assert property (!topup_en && vm == bpc_pkg::VM_OPEN |=> !valve_open)
		else $error("manual open passed enable");
	remote_off_a: assert property (!remote_on && !ctrl_q[bpc_pkg::B_KOFF]
		|=> pump_run == 2'b00 && !valve_open)
		else $error("run during remote off");
	burner_a: assert property (burner |=> burner_fault_output)
		else $error("burner relay missed");
	run_relay_a: assert property (collective_run_output == |pump_run
		&& per_pump_run_output == pump_run)
		else $error("run relays disagree");
	pump_fault_a: assert property (|pump_fault_contact |=> combined_pump_fault_output)
		else $error("combined fault missed");
	coll_fault_a: assert property (sys_fault |=> collective_fault_output)
		else $error("collective fault missed");
	alarm_stop_a: assert property ($rose(v_alarm_q) |=> pump_run == 2'b00 && !valve_open)
		else $error("alarm did not stop");
	stop_delay_a: assert property (st_q == bpc_pkg::P_STOP && dly_s_q <= 32'(dly_q) && allow
		|=> st_q != bpc_pkg::P_IDLE)
		else $error("stopped before delay");

	kick_c: cover property (st_q == bpc_pkg::P_IDLE ##1 st_q == bpc_pkg::P_KICK);
	fill_c: cover property ($rose(valve_open));
	freq_c: cover property ($rose(f_alarm_q));
	swap_c: cover property (pump_run == 2'b01 ##[1:20] pump_run == 2'b10);
endmodule : booster_pump_controller

// >>> common/bpc_pkg.sv
// Constants for the booster pump controller: register map, fields, timing.
// Assumes a 25 MHz system clock and a 32-bit classic Wishbone slave port.
package bpc_pkg;
	// Register byte offsets
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_SETPT = 8'h04;
	localparam logic [7:0] A_THR   = 8'h08;
	localparam logic [7:0] A_DLY   = 8'h0C;
	localparam logic [7:0] A_VMAX  = 8'h10;
	localparam logic [7:0] A_KICK  = 8'h14;
	localparam logic [7:0] A_LIM   = 8'h18;
	localparam logic [7:0] A_STAT  = 8'h1C;
	localparam logic [7:0] A_IDLE  = 8'h20;
	// Control fields
	localparam int B_DRV  = 0;
	localparam int B_CYC  = 1;
	localparam int B_KICK = 2;
	localparam int B_KOFF = 3;
	localparam int B_VM   = 4;
	localparam int B_CLR  = 6;
	localparam logic [6:0] CTRL_RST = 7'h06;
	localparam logic [1:0] VM_AUTO = 2'h0;
	localparam logic [1:0] VM_OPEN = 2'h1;
	localparam logic [1:0] VM_SHUT = 2'h2;
	// Timing
	localparam int CLK_HZ     = 25_000_000;
	localparam int TICK_S     = 1;
	localparam int TICK_CYC   = CLK_HZ * TICK_S;
	localparam int S_PER_MIN  = 60;
	localparam int CYCLE_H    = 6;
	localparam logic [31:0] CYCLE_S = 32'(CYCLE_H * 3600);
	// Top-up interval bands and alarm delays, in seconds (minutes times S_PER_MIN)
	localparam logic [31:0] GAP6 = 32'(6 * S_PER_MIN);
	localparam logic [31:0] GAP5 = 32'(5 * S_PER_MIN);
	localparam logic [31:0] GAP4 = 32'(4 * S_PER_MIN);
	localparam logic [31:0] GAP3 = 32'(3 * S_PER_MIN);
	localparam logic [31:0] DLY6 = 32'(60 * S_PER_MIN);
	localparam logic [31:0] DLY5 = 32'(45 * S_PER_MIN);
	localparam logic [31:0] DLY4 = 32'(25 * S_PER_MIN);
	localparam logic [31:0] DLY3 = 32'(15 * S_PER_MIN);
	typedef enum logic [1:0] {P_IDLE, P_RUN, P_STOP, P_KICK} pump_st_t;
endpackage : bpc_pkg

// >>> test/plant_model.sv
// Far side of the controller: pressure sensor and top-up tank float.
// Assumes the bench sets the pressure and pulses drain to drop the level.
`timescale 1ns/1ns
module plant_model #(
	parameter int FILL = 60
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// From the controller
	input  wire logic        valve_open,
	// From the bench
	input  wire logic        drain,
	input  wire logic [15:0] p_set,
	// To the controller
	output logic      [15:0] pressure,
	output logic             float_ok
);
	int   fill_q;
	int   fill_d;
	logic float_d;

	assign pressure = p_set;

	// Tank refills only while the valve is open, so a shut valve leaves the level low
	always_comb begin
		fill_d  = fill_q;
		float_d = float_ok;
		if (drain) begin
			float_d = 1'b0;
			fill_d  = 0;
		end else if (!float_ok && valve_open) begin
			fill_d = fill_q + 1;
			if (fill_q == FILL - 1)
				float_d = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			float_ok <= 1'b1;
			fill_q   <= 0;
		end else begin
			float_ok <= float_d;
			fill_q   <= fill_d;
		end
	end
endmodule : plant_model

// >>> test/booster_pump_controller_test.sv
// Self-checking bench for the booster pump controller over Wishbone.
// Assumes a short tick (10 cycles per second) so delays run in a few cycles.
`timescale 1ns/1ns
module booster_pump_controller_test;
	localparam int TK = 10;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        ack;
	logic        remote_on = 1'b1;
	logic        topup_en = 1'b1;
	logic        dry_ok = 1'b1;
	logic [1:0]  pfc = 2'h0;
	logic        sensor_err = 1'b0;
	logic        drain = 1'b0;
	logic [15:0] p_set = 16'h03B6;
	logic [15:0] pressure;
	logic        float_ok;
	logic [1:0]  pump_run;
	logic [1:0]  ppr;
	logic        valve_open;
	logic        crun;
	logic        cflt;
	logic        bflt;
	logic        pflt;
	logic [31:0] q;
	int          fail_count = 0;
	int          comparisons = 0;
	int          cycles = 0;
	int          n = 0;

	booster_pump_controller #(.TICK_CYCLES(TK)) i_booster_pump_controller (
		.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.remote_on(remote_on), .topup_en(topup_en), .float_ok(float_ok), .dry_ok(dry_ok),
		.pump_fault_contact(pfc), .sensor_err(sensor_err), .pressure(pressure),
		.pump_run(pump_run), .valve_open(valve_open), .collective_run_output(crun),
		.collective_fault_output(cflt), .burner_fault_output(bflt),
		.per_pump_run_output(ppr), .combined_pump_fault_output(pflt));

	plant_model #(.FILL(60)) i_plant_model (
		.mclk(mclk), .rst_b(rst_b), .valve_open(valve_open), .drain(drain),
		.p_set(p_set), .pressure(pressure), .float_ok(float_ok));

	initial begin
		forever #20 mclk = ~mclk;
	end

	// Hang guard, well above the length of the sequence
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count = fail_count + 1;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : chk

	// Request held until ack is seen at a rising edge, released at that edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge mclk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		sel  <= 4'hF;
		wdat <= d;
		do @(posedge mclk); while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
	endtask : wr

	task automatic cy(input int n);
		repeat (n) @(negedge mclk);
	endtask : cy

	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask : tdone

	initial begin
		repeat (8) @(posedge mclk);
		rst_b <= 1'b1;
		wb(1'b0, bpc_pkg::A_CTRL, 32'h0, q);
		chk(q, 32'(bpc_pkg::CTRL_RST));
		wb(1'b0, bpc_pkg::A_LIM, 32'h0, q);
		chk(q, 32'hFFFF0000);
		wb(1'b0, 8'h24, 32'h0, q);
		chk(q, 32'h0);
		tdone("reset");
		// Threshold window 900..1100 around 1000
		wr(bpc_pkg::A_SETPT, 32'h000003E8);
		wr(bpc_pkg::A_THR, 32'h0064FF9C);
		wr(bpc_pkg::A_DLY, 32'h00000002);
		wr(bpc_pkg::A_CTRL, 32'h00000007);
		@(posedge mclk) p_set <= 16'd950;
		cy(4);
		chk(32'(pump_run), 32'h0);
		@(posedge mclk) p_set <= 16'd899;
		cy(3);
		chk(32'(pump_run), 32'h2);
		chk(32'(ppr), 32'h2);
		chk(32'(crun), 32'h1);
		@(posedge mclk) p_set <= 16'd1101;
		cy(18);
		chk(32'(pump_run), 32'h2);
		cy(30);
		chk(32'(pump_run), 32'h0);
		chk(32'(crun), 32'h0);
		@(posedge mclk) p_set <= 16'd800;
		cy(3);
		chk(32'(pump_run), 32'h1);
		chk(32'(ppr), 32'h1);
		tdone("pressure");
		@(posedge mclk) remote_on <= 1'b0;
		cy(3);
		chk(32'(pump_run), 32'h0);
		@(posedge mclk) p_set <= 16'd1200;
		@(posedge mclk) remote_on <= 1'b1;
		tdone("remote");
		@(posedge mclk) pfc <= 2'h1;
		cy(3);
		chk(32'(pflt), 32'h1);
		chk(32'(cflt), 32'h1);
		@(posedge mclk) pfc <= 2'h3;
		cy(3);
		chk(32'(pflt), 32'h1);
		@(posedge mclk) pfc <= 2'h0;
		dry_ok <= 1'b0;
		cy(3);
		chk(32'(pflt), 32'h0);
		chk(32'(bflt), 32'h1);
		@(posedge mclk) dry_ok <= 1'b1;
		sensor_err <= 1'b1;
		cy(3);
		chk(32'(bflt), 32'h1);
		@(posedge mclk) sensor_err <= 1'b0;
		cy(3);
		chk(32'(bflt), 32'h0);
		chk(32'(cflt), 32'h0);
		tdone("faults");
		@(posedge mclk) drain <= 1'b1;
		@(posedge mclk) drain <= 1'b0;
		cy(3);
		chk(32'(valve_open), 32'h1);
		@(posedge mclk) topup_en <= 1'b0;
		cy(3);
		chk(32'(valve_open), 32'h0);
		wr(bpc_pkg::A_CTRL, 32'h00000017);
		cy(3);
		chk(32'(valve_open), 32'h0);
		@(posedge mclk) topup_en <= 1'b1;
		wr(bpc_pkg::A_CTRL, 32'h00000007);
		cy(70);
		chk(32'(float_ok), 32'h1);
		chk(32'(valve_open), 32'h0);
		tdone("valve");
		// Valve limit of 2 s trips before the tank refills
		wr(bpc_pkg::A_VMAX, 32'h00000002);
		@(posedge mclk) p_set <= 16'd800;
		drain <= 1'b1;
		@(posedge mclk) drain <= 1'b0;
		cy(3);
		chk(32'(valve_open), 32'h1);
		chk(32'(pump_run), 32'h2);
		cy(40);
		chk(32'(valve_open), 32'h0);
		chk(32'(pump_run), 32'h0);
		chk(32'(cflt), 32'h1);
		wb(1'b0, bpc_pkg::A_STAT, 32'h0, q);
		chk(q & 32'h10, 32'h10);
		tdone("valve alarm");
		// Kick after one idle minute exercises the standby pump
		wr(bpc_pkg::A_VMAX, 32'h00000000);
		@(posedge mclk) p_set <= 16'h03E8;
		wr(bpc_pkg::A_CTRL, 32'h00000047);
		cy(3);
		chk(32'(cflt), 32'h0);
		wr(bpc_pkg::A_KICK, 32'h00020001);
		while (n < 800 && pump_run == 2'b00) begin
			@(negedge mclk);
			n = n + 1;
		end
		chk(32'(pump_run), 32'h1);
		chk(32'(ppr), 32'h1);
		wb(1'b0, bpc_pkg::A_IDLE, 32'h0, q);
		chk(q, 32'h0);
		cy(40);
		chk(32'(pump_run), 32'h0);
		tdone("kick");
		report_and_stop();
	end
endmodule : booster_pump_controller_test
